// File: include/region_prot_pkg.sv
// Purpose: shared constants and types for the region attribute protection unit
// Assumes: 32-bit register port, eight regions
// Notes: offsets are byte addresses on the private peripheral bus
package region_prot_pkg;
    localparam int NUM_REGIONS = 8;
    localparam logic [31:0] SELECT_OFS = 32'hE000ED98;
    localparam logic [31:0] BASE_OFS = 32'hE000ED9C;
    localparam logic [31:0] ATTR_OFS = 32'hE000EDA0;
    localparam logic [31:0] ALIAS_SPAN = 32'h00000008;
    localparam int NUM_ALIAS = 4;
    localparam int BASE_VALID_BIT = 4;
    localparam int ATTR_ENABLE_BIT = 0;
    localparam int ATTR_SIZE_LSB = 1;
    localparam int ATTR_SRD_LSB = 8;
    localparam int ATTR_B_BIT = 16;
    localparam int ATTR_C_BIT = 17;
    localparam int ATTR_S_BIT = 18;
    localparam int ATTR_TEX_LSB = 19;
    localparam int ATTR_AP_LSB = 24;
    localparam int ATTR_XN_BIT = 28;
    localparam logic [4:0] MIN_SIZE_FIELD = 5'h04;
    localparam logic [4:0] SUBREGION_MIN_SIZE = 5'h07;
    localparam logic [31:0] ATTR_RESET = 32'h00000000;
    localparam logic [31:0] BASE_RESET = 32'h00000000;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [7:0] SRD_NONE = 8'h00;
    localparam int FAULT_IACC_BIT = 0;
    localparam int FAULT_DACC_BIT = 1;
    localparam int FAULT_NOMATCH_BIT = 2;
    localparam int FAULT_RESERVED_BIT = 3;
    localparam int FAULT_ADDR_VALID_BIT = 7;

    typedef enum logic [1:0] {
        POL_NONCACHE,
        POL_WB_RWA,
        POL_WT_NWA,
        POL_WB_NWA
    } cache_policy_t;

    typedef enum logic [2:0] {
        MEM_STRONG,
        MEM_DEVICE,
        MEM_NORMAL,
        MEM_IMPL,
        MEM_RESERVED
    } mem_type_t;

    typedef struct packed {
        mem_type_t mem_type;
        logic shareable;
        cache_policy_t outer_cache_policy;
        cache_policy_t inner_cache_policy;
    } mem_attr_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic privileged;
        logic [31:0] addr;
    } core_access_t;

    typedef struct packed {
        logic sel;
        logic write;
        logic [31:0] addr;
        logic [3:0] strobe;
        logic [31:0] wdata;
    } reg_req_t;
endpackage

// File: rtl/region_table.sv
// Purpose: per-region base and attribute storage with registered read port
// Assumes: one write per cycle, read index from same clock
// Notes: match side sees all regions at once
module region_table
    import region_prot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic base_we,
    input wire logic [3:0] attr_be,
    input wire logic [2:0] wr_idx,
    input wire logic [31:0] wdata,
    // read port
    input wire logic [2:0] rd_idx,
    output logic [31:0] rd_base,
    output logic [31:0] rd_attr,
    // flat view for matching
    output logic [NUM_REGIONS*32-1:0] all_base,
    output logic [NUM_REGIONS*32-1:0] all_attr
);
    logic [31:0] base_ff [NUM_REGIONS]; // base address per region
    logic [31:0] attr_ff [NUM_REGIONS]; // attribute and size per region

    ////////////////////////////////////////////////////////////////
    // storage, byte lanes honoured on the attribute word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                base_ff[i] <= BASE_RESET;
                attr_ff[i] <= ATTR_RESET;
            end
        end else begin
            if (base_we) begin
                base_ff[wr_idx] <= {wdata[31:5], 5'h00};
            end
            for (int b = 0; b < 4; b++) begin
                if (attr_be[b]) begin
                    attr_ff[wr_idx][b*8 +: 8] <= wdata[b*8 +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // registered read data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_base <= 32'h00000000;
            rd_attr <= 32'h00000000;
        end else begin
            rd_base <= base_ff[rd_idx];
            rd_attr <= attr_ff[rd_idx];
        end
    end

    // flatten for the combinational match
    always_comb begin
        for (int i = 0; i < NUM_REGIONS; i++) begin
            all_base[i*32 +: 32] = base_ff[i];
            all_attr[i*32 +: 32] = attr_ff[i];
        end
    end
endmodule

// File: rtl/region_attribute_protection_unit.sv
// Purpose: region based memory protection with attribute decode
// Assumes: core access and register request arrive on clk; protection always on
// Notes: read data one cycle after the request; the fault is combinational
//
// Behaviour
// - b001 plain: normal non-cacheable, b001 b-only reserved
// - b001 with c and b: write-back read/write allocate
// - don't-care bits ignored, b010 others reserved
// - top extension bit: normal cached, split policies
// - policy codes: nc, wb-rwa, wt, wb-nwa
// - violation raises fault and records cause flags
// - select, base, attribute at consecutive words
// - alias base/attribute pairs for four regions
// - valid base write also loads select
// - register writes take effect in order
// - large regions split into eight subregions
// - mask lsb is lowest subregion
// - disabled subregion falls through, else fault
// - attribute register byte/half/word, others word only
// - unaligned register accesses unsupported
// - eight regions, highest matching number governs
// - region size two to size plus one
// - valid reads zero, region field reads select
module region_attribute_protection_unit
    import region_prot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port from the private peripheral bus
    input wire reg_req_t reg_req,
    output logic reg_ack,
    output logic reg_err,
    output logic [31:0] reg_rdata,
    // core access under check
    input wire core_access_t core_acc,
    output logic acc_allow,
    output logic acc_fault,
    output mem_attr_t acc_attr,
    // fault cause, write one to clear
    output logic [7:0] memmanage_fault_cause,
    output logic [31:0] fault_addr,
    input wire logic [7:0] fault_clear
);
    ////////////////////////////////////////////////////////////////
    // functions

    // two-bit policy code to policy
    function automatic cache_policy_t decode_policy(input logic [1:0] code);
        cache_policy_t p;
        unique case (code)
            2'h0: p = POL_NONCACHE;
            2'h1: p = POL_WB_RWA;
            2'h2: p = POL_WT_NWA;
            2'h3: p = POL_WB_NWA;
        endcase
        return p;
    endfunction

    // extension, c, b, s to memory attributes
    function automatic mem_attr_t decode_attr(input logic [31:0] a);
        mem_attr_t m;
        logic [2:0] type_extension_field;
        logic c;
        logic b;
        logic s;
        type_extension_field = a[ATTR_TEX_LSB +: 3];
        c = a[ATTR_C_BIT];
        b = a[ATTR_B_BIT];
        s = a[ATTR_S_BIT];
        m.mem_type = MEM_RESERVED;
        m.shareable = 1'b0;
        m.outer_cache_policy = POL_NONCACHE;
        m.inner_cache_policy = POL_NONCACHE;
        if (type_extension_field[2]) begin
            // cached memory with independent outer and inner policy
            m.mem_type = MEM_NORMAL;
            m.shareable = s;
            m.outer_cache_policy = decode_policy(type_extension_field[1:0]);
            m.inner_cache_policy = decode_policy({c, b});
        end else begin
            unique case (type_extension_field[1:0])
                2'h0: begin
                    // strongly ordered and device ignore s
                    if (!c) begin
                        m.mem_type = b ? MEM_DEVICE : MEM_STRONG;
                        m.shareable = 1'b1;
                    end else begin
                        m.mem_type = MEM_NORMAL;
                        m.shareable = s;
                        m.outer_cache_policy = b ? POL_WB_NWA : POL_WT_NWA;
                        m.inner_cache_policy = b ? POL_WB_NWA : POL_WT_NWA;
                    end
                end
                2'h1: begin
                    if (!c && !b) begin
                        m.mem_type = MEM_NORMAL;
                        m.shareable = s;
                    end else if (c && b) begin
                        m.mem_type = MEM_NORMAL;
                        m.shareable = s;
                        m.outer_cache_policy = POL_WB_RWA;
                        m.inner_cache_policy = POL_WB_RWA;
                    end else if (c) begin
                        m.mem_type = MEM_IMPL; // s ignored
                    end else begin
                        m.mem_type = MEM_RESERVED;
                    end
                end
                2'h2: begin
                    // non-shared device whatever s holds
                    if (!c && !b) begin
                        m.mem_type = MEM_DEVICE;
                    end else begin
                        m.mem_type = MEM_RESERVED;
                    end
                end
                2'h3: m.mem_type = MEM_RESERVED;
            endcase
        end
        return m;
    endfunction

    // region hit with subregion exclusion
    function automatic logic region_hit(input logic [31:0] base, input logic [31:0] a,
                                        input logic [31:0] addr);
        logic [4:0] sz;
        logic [5:0] n;
        logic [31:0] mask;
        logic [2:0] sub;
        logic hit;
        sz = a[ATTR_SIZE_LSB +: 5];
        n = 6'(sz) + 6'h01;
        if (sz < MIN_SIZE_FIELD) begin
            n = 6'(MIN_SIZE_FIELD) + 6'h01;
        end
        mask = (n >= 6'h20) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
        hit = a[ATTR_ENABLE_BIT] && ((addr & ~mask) == (base & ~mask));
        sub = 3'((addr & mask) >> (n - 6'h03));
        if (sz >= SUBREGION_MIN_SIZE && a[ATTR_SRD_LSB + sub]) begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////
    // register address decode
    wire logic [31:0] ofs = reg_req.addr - SELECT_OFS; // offset from select
    wire logic in_range = (reg_req.addr >= SELECT_OFS) &&
        (reg_req.addr < ATTR_OFS + ALIAS_SPAN * 32'(NUM_ALIAS - 1) + 32'h00000004);
    wire logic hit_select = in_range && (ofs[5:2] == 4'h0);
    wire logic hit_base = in_range && (ofs[5:2] != 4'h0) && ofs[2]; // base and aliases
    wire logic hit_attr = in_range && (ofs[5:2] != 4'h0) && !ofs[2];
    // word only except attribute: byte or aligned half allowed
    wire logic full_word = (reg_req.strobe == 4'hF);
    wire logic half_ok = (reg_req.strobe == 4'h3) || (reg_req.strobe == 4'hC);
    wire logic byte_ok = (reg_req.strobe == 4'h1) || (reg_req.strobe == 4'h2) ||
        (reg_req.strobe == 4'h4) || (reg_req.strobe == 4'h8);
    wire logic lanes_ok = hit_attr ? (full_word || half_ok || byte_ok) : full_word;
    wire logic addr_aligned = (reg_req.addr[1:0] == 2'h0);
    wire logic req_ok = reg_req.sel && in_range && addr_aligned &&
        (!reg_req.write || lanes_ok);
    wire logic wr_ok = req_ok && reg_req.write;

    ////////////////////////////////////////////////////////////////
    // region select register
    logic [2:0] select_ff; // current region
    wire logic base_valid = reg_req.wdata[BASE_VALID_BIT];
    wire logic [2:0] wr_region = (hit_base && base_valid) ? reg_req.wdata[2:0] : select_ff;

    // select follows a direct write or a valid base write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            select_ff <= SELECT_RESET;
        end else if (wr_ok && hit_select) begin
            select_ff <= reg_req.wdata[2:0];
        end else if (wr_ok && hit_base && base_valid) begin
            select_ff <= reg_req.wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // region storage; writes are applied in arrival order, one a cycle
    wire logic base_we = wr_ok && hit_base;
    wire logic [3:0] attr_be = (wr_ok && hit_attr) ? reg_req.strobe : 4'h0;
    logic [31:0] rd_base;
    logic [31:0] rd_attr;
    logic [NUM_REGIONS*32-1:0] all_base;
    logic [NUM_REGIONS*32-1:0] all_attr;

    region_table u_table (
        .clk(clk),
        .resetn(resetn),
        .base_we(base_we),
        .attr_be(attr_be),
        .wr_idx(wr_region),
        .wdata(reg_req.wdata),
        .rd_idx(select_ff),
        .rd_base(rd_base),
        .rd_attr(rd_attr),
        .all_base(all_base),
        .all_attr(all_attr)
    );

    ////////////////////////////////////////////////////////////////
    // read answer, one cycle later to line up with the table read
    logic rd_pend_ff; // read in flight
    logic [1:0] rd_kind_ff; // 0 select, 1 base, 2 attribute
    logic err_ff; // refused request
    logic ack_ff; // answer strobe

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_pend_ff <= 1'b0;
            rd_kind_ff <= 2'h0;
            err_ff <= 1'b0;
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= reg_req.sel;
            err_ff <= reg_req.sel && !req_ok;
            rd_pend_ff <= req_ok && !reg_req.write;
            rd_kind_ff <= hit_select ? 2'h0 : (hit_base ? 2'h1 : 2'h2);
        end
    end

    // region field reads select, valid reads zero
    wire logic [31:0] base_view = {rd_base[31:5], 1'b0, 1'b0, select_ff};
    wire logic [31:0] rd_mux = (rd_kind_ff == 2'h0) ? {29'h0, select_ff} :
        (rd_kind_ff == 2'h1) ? base_view : rd_attr;
    assign reg_ack = ack_ff;
    assign reg_err = err_ff;
    assign reg_rdata = (rd_pend_ff && !err_ff) ? rd_mux : 32'h00000000;

    ////////////////////////////////////////////////////////////////
    // access check: highest numbered hit governs, all in one cycle
    logic [NUM_REGIONS-1:0] hits; // per region hit
    logic any_hit;
    logic [31:0] win_attr;

    always_comb begin
        any_hit = 1'b0;
        win_attr = ATTR_RESET;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            hits[i] = region_hit(all_base[i*32 +: 32], all_attr[i*32 +: 32], core_acc.addr);
            if (hits[i]) begin
                any_hit = 1'b1;
                win_attr = all_attr[i*32 +: 32];
            end
        end
    end

    wire mem_attr_t win_decoded = decode_attr(win_attr);
    wire logic [2:0] ap = win_attr[ATTR_AP_LSB +: 3];
    // permission: ap 0 none, 1/5 priv, 2 priv rw user ro, 3 rw, 6/7 ro
    wire logic ap_read = core_acc.privileged ? (ap != 3'h0 && ap != 3'h4) :
        (ap == 3'h2 || ap == 3'h3 || ap == 3'h6 || ap == 3'h7);
    wire logic ap_write = core_acc.privileged ? (ap == 3'h1 || ap == 3'h2 || ap == 3'h3) :
        (ap == 3'h3);
    wire logic perm_ok = core_acc.write ? ap_write : ap_read;
    wire logic xn_block = core_acc.fetch && win_attr[ATTR_XN_BIT];
    wire logic reserved_type = (win_decoded.mem_type == MEM_RESERVED);
    wire logic violate = core_acc.valid &&
        (!any_hit || !perm_ok || xn_block || reserved_type);

    // fault and block in the presenting cycle
    assign acc_fault = violate;
    assign acc_allow = core_acc.valid && !violate;
    assign acc_attr = win_decoded;

    ////////////////////////////////////////////////////////////////
    // cause flags: a new fault wins over a clear in the same cycle
    logic [7:0] cause_ff;
    logic [31:0] addr_ff;
    wire logic [7:0] new_cause = {violate, 3'h0, violate && reserved_type,
        violate && !any_hit, violate && !core_acc.fetch, violate && core_acc.fetch};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cause_ff <= 8'h00;
        end else begin
            cause_ff <= (cause_ff & ~fault_clear) | new_cause;
        end
    end

    // address of the first unreported fault
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_ff <= 32'h00000000;
        end else if (violate && (!cause_ff[FAULT_ADDR_VALID_BIT] || fault_clear[FAULT_ADDR_VALID_BIT])) begin
            addr_ff <= core_acc.addr;
        end
    end

    assign memmanage_fault_cause = cause_ff;
    assign fault_addr = addr_ff;
endmodule

// File: verif/region_prot_checker_assertions.sv
// Purpose: port-level checks on the protection unit
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of the top module
module region_prot_checker
    import region_prot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire reg_req_t reg_req,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic [31:0] reg_rdata,
    // access check and fault record
    input wire core_access_t core_acc,
    input wire logic acc_allow,
    input wire logic acc_fault,
    input wire logic [7:0] memmanage_fault_cause,
    input wire logic [31:0] fault_addr,
    input wire logic [7:0] fault_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////
    a_ack_one_cycle: assert property (reg_req.sel |=> reg_ack)
        else $error("ack missing after request");
    a_ack_no_request: assert property (!reg_req.sel |=> !reg_ack && !reg_err)
        else $error("answer without request");
    a_unaligned_err: assert property (reg_req.sel && reg_req.addr[1:0] != 2'h0 |=> reg_err)
        else $error("unaligned access accepted");
    a_select_word_only: assert property (reg_req.sel && reg_req.write
        && reg_req.addr == SELECT_OFS && reg_req.strobe != 4'hF |=> reg_err)
        else $error("partial select write accepted");
    a_valid_reads_zero: assert property (reg_req.sel && !reg_req.write
        && reg_req.addr == BASE_OFS |=> reg_rdata[BASE_VALID_BIT] == 1'b0)
        else $error("valid bit read back set");
    a_one_verdict: assert property (core_acc.valid |-> acc_allow != acc_fault)
        else $error("access both allowed and faulted");
    a_idle_no_fault: assert property (!core_acc.valid |-> !acc_fault && !acc_allow)
        else $error("verdict without access");
    a_fault_flags: assert property (acc_fault |=> memmanage_fault_cause[7]
        && ($past(core_acc.fetch) ? memmanage_fault_cause[0] : memmanage_fault_cause[1]))
        else $error("fault cause not recorded");
    a_fault_addr_load: assert property (acc_fault && !memmanage_fault_cause[7]
        |=> fault_addr == $past(core_acc.addr))
        else $error("fault address not captured");
    a_fault_addr_hold: assert property (memmanage_fault_cause[7] && !fault_clear[7]
        |=> $stable(fault_addr))
        else $error("fault address overwritten");
    a_cause_sticky: assert property (memmanage_fault_cause[1] && !fault_clear[1]
        |=> memmanage_fault_cause[1])
        else $error("cause flag dropped without clear");
endmodule

bind region_attribute_protection_unit region_prot_checker u_chk (.clk, .resetn, .reg_req, .reg_ack,
    .reg_err, .reg_rdata, .core_acc, .acc_allow, .acc_fault, .memmanage_fault_cause, .fault_addr,
    .fault_clear);

// File: verif/core_model.sv
// Purpose: behavioural core issuing register requests and memory accesses
// Assumes: drives on the falling edge, the unit samples on the rising edge
// Notes: released lines are inverted so a stale value never looks valid
module core_model
    import region_prot_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output reg_req_t reg_req,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic [31:0] reg_rdata,
    // access side
    output core_access_t core_acc,
    output logic [7:0] fault_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rd_last; // data of the last answer
    logic err_last; // refusal of the last answer
    logic ack_last; // answer strobe seen with the last answer

    initial begin
        reg_req = '0;
        core_acc = '0;
        fault_clear = 8'h00;
    end

    // back-to-back words, one per cycle; only the last answer is kept
    task automatic reg_op(input logic wr, input logic [31:0] a, input logic [3:0] be,
                          input logic [31:0] d [4], input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            reg_req = '{1'b1, wr, a + 32'(4 * i), be, d[i]};
        end
        // the answer stands only until the next rising edge, so take it mid-cycle
        @(negedge clk);
        rd_last = reg_rdata;
        err_last = reg_err;
        ack_last = reg_ack;
        reg_req = '{1'b0, 1'b0, ~a, 4'h0, ~d[n - 1]};
    endtask

    task automatic access(input logic [31:0] a, input logic fetch);
        @(negedge clk);
        core_acc = '{1'b1, 1'b0, fetch, 1'b1, a};
    endtask

    task automatic idle();
        @(negedge clk);
        core_acc = '{1'b0, 1'b0, 1'b0, 1'b0, ~core_acc.addr};
    endtask

    // one-cycle write-one-to-clear pulse
    task automatic clear_cause(input logic [7:0] m);
        @(negedge clk);
        fault_clear = m;
        @(negedge clk);
        fault_clear = 8'h00;
    endtask
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for the region protection unit
// Assumes: core model drives on the falling edge
// Notes: attribute bytes are {type, share, outer, inner}
module tb_top
    import region_prot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic resetn;
    reg_req_t reg_req;
    logic reg_ack, reg_err, acc_allow, acc_fault;
    logic [31:0] reg_rdata, fault_addr, a9;
    core_access_t core_acc;
    mem_attr_t acc_attr;
    logic [7:0] memmanage_fault_cause, fault_clear;
    int num_errors = 0;
    int n_checks = 0;

    region_attribute_protection_unit uut (.clk, .resetn, .reg_req, .reg_ack, .reg_err, .reg_rdata,
        .core_acc, .acc_allow, .acc_fault, .acc_attr, .memmanage_fault_cause, .fault_addr, .fault_clear);
    core_model cm (.clk, .reg_req, .reg_ack, .reg_err, .reg_rdata, .core_acc, .fault_clear);

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // enc is {tex, c, b, s}; full access, enabled
    function automatic logic [31:0] attr(input logic [5:0] e, input logic [7:0] subregion_disable_mask, input logic [4:0] sz);
        return {8'h03, 2'h0, e[5:3], e[0], e[2], e[1], subregion_disable_mask, 2'h0, sz, 1'b1};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        cm.reg_op(1'b1, a, 4'hF, '{d, 0, 0, 0}, 1);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        cm.reg_op(1'b0, a, 4'hF, '{0, 0, 0, 0}, 1);
        chk("read data", cm.rd_last, exp);
        chk("read ack", 32'(cm.ack_last), 32'h1);
    endtask

    // reserved encodings leave the rest open, device leaves policies open
    task automatic at(input logic [31:0] a, input logic [7:0] exp);
        logic [7:0] m;
        m = (exp[7:5] == 3'h4) ? 8'hE0 : (exp[7:5] == 3'h1) ? 8'hF0 : 8'hFF;
        cm.access(a, 1'b0);
        #5;
        chk("attributes", 32'(acc_attr & m), 32'(exp & m));
        cm.idle();
    endtask

    task automatic acc_chk(input logic [31:0] a, input logic fetch, input logic ef);
        cm.access(a, fetch);
        #5;
        chk("fault", 32'(acc_fault), 32'(ef));
        chk("allow", 32'(acc_allow), 32'(!ef));
        @(posedge clk);
        #1;
        cm.idle();
        if (ef) begin
            chk("cause", 32'(memmanage_fault_cause & 8'h83), {24'h0, 6'h20, ~fetch, fetch});
            chk("fault address", fault_addr, a);
            cm.clear_cause(8'hFF);
        end
    endtask

    ////////////////////////////////////////
    task automatic t_reset();
        rd(SELECT_OFS, 32'h0);
        rd(BASE_OFS, 32'h0);
        rd(ATTR_OFS, 32'h0);
        acc_chk(32'h100, 1'b0, 1'b1);
        chk("cause", 32'(memmanage_fault_cause), 32'h0);
    endtask

    // b000 entries first: strongly ordered, device, write-through, write-back
    task automatic t_encodings();
        logic [5:0] enc [14] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h09, 6'h0A, 6'h0E,
            6'h11, 6'h10, 6'h15, 6'h2D, 6'h36, 6'h23, 6'h38};
        logic [7:0] exp [14] = '{8'h10, 8'h30, 8'h4A, 8'h4F, 8'h50, 8'h80, 8'h45,
            8'h20, 8'h20, 8'h80, 8'h56, 8'h4B, 8'h51, 8'h4C};
        wr(SELECT_OFS, 32'h0);
        wr(BASE_OFS, 32'h0);
        for (int i = 0; i < 14; i++) begin
            wr(ATTR_OFS, 32'h0);
            wr(ATTR_OFS, attr(enc[i], 8'h00, 5'h09));
            at(32'h40, exp[i]);
        end
        cm.clear_cause(8'hFF);
    endtask

    task automatic t_subregion();
        logic [31:0] adr [5] = '{32'h7C, 32'h80, 32'h37C, 32'h380, 32'h400};
        logic flt [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        wr(ATTR_OFS, 32'h0);
        wr(ATTR_OFS, attr(6'h09, 8'h81, 5'h09));
        for (int i = 0; i < 5; i++) begin
            acc_chk(adr[i], i[0], flt[i]);
        end
    endtask

    task automatic t_overlap();
        wr(BASE_OFS, 32'h11);
        rd(SELECT_OFS, 32'h1);
        rd(BASE_OFS, 32'h1);
        wr(ATTR_OFS + ALIAS_SPAN, attr(6'h2E, 8'h00, 5'h04));
        at(32'h10, 8'h47);
        acc_chk(32'h50, 1'b0, 1'b1);
        wr(SELECT_OFS, 32'h0);
        cm.reg_op(1'b1, ATTR_OFS, 4'h2, '{32'h0, 0, 0, 0}, 1);
        chk("byte write", 32'(cm.err_last), 32'h0);
        at(32'h10, 8'h47);
        at(32'h50, 8'h50);
    endtask

    task automatic t_burst();
        a9 = attr(6'h09, 8'h00, 5'h09);
        cm.reg_op(1'b1, SELECT_OFS, 4'hF, '{32'h2, 32'h1000, a9, 0}, 3);
        rd(SELECT_OFS, 32'h2);
        acc_chk(32'h1010, 1'b0, 1'b0);
        cm.reg_op(1'b1, BASE_OFS, 4'hF, '{32'h2013, a9, 32'h3014, a9}, 4);
        rd(SELECT_OFS, 32'h4);
        acc_chk(32'h2010, 1'b0, 1'b0);
        acc_chk(32'h3010, 1'b0, 1'b0);
    endtask

    task automatic t_refuse();
        logic [31:0] adr [5] = '{SELECT_OFS, BASE_OFS + 32'h1, ATTR_OFS, ATTR_OFS, 32'hE000EDC0};
        logic [3:0] be [5] = '{4'h3, 4'hF, 4'h6, 4'hC, 4'hF};
        logic ee [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            cm.reg_op(1'b1, adr[i], be[i], '{a9, 0, 0, 0}, 1);
            chk("refusal", 32'(cm.err_last), 32'(ee[i]));
        end
        rd(SELECT_OFS, 32'h4);
    endtask

    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_encodings();
        t_subregion();
        t_overlap();
        t_burst();
        t_refuse();
        test_done();
    end

    // generous bound, the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule
